// file: design/ffq_params.svh
/*
  register offsets, field positions, reset values and depths of the
  buffer bookkeeping and event status block.
  assumes a byte-wide register port with byte addresses.
*/
`ifndef FFQ_PARAMS_SVH
`define FFQ_PARAMS_SVH
`define FFQ_ADDR_CMD 8'h00
`define FFQ_ADDR_BUF_CTRL 8'h02
`define FFQ_ADDR_THRESHOLD 8'h03
`define FFQ_ADDR_FILL_COUNT 8'h04
`define FFQ_ADDR_DATA_PORT 8'h05
`define FFQ_ADDR_IRQ_FIRST 8'h06
`define FFQ_ADDR_ERR_FLAGS 8'h0A
`define FFQ_ADDR_PTR 8'h0B
`define FFQ_CTRL_DEPTH_SEL 7
`define FFQ_CTRL_NEAR_FULL 6
`define FFQ_CTRL_NEAR_EMPTY 5
`define FFQ_CTRL_CLEAR 4
`define FFQ_CTRL_THR_EXT 2
`define FFQ_IRQ_SET 7
`define FFQ_IRQ_NEAR_FULL 6
`define FFQ_IRQ_NEAR_EMPTY 5
`define FFQ_IRQ_CMD_DONE 4
`define FFQ_IRQ_TX_DONE 3
`define FFQ_IRQ_RX_DONE 2
`define FFQ_IRQ_ERROR 1
`define FFQ_IRQ_SOF 0
`define FFQ_ERR_OVERFLOW 1
`define FFQ_RESET_BYTE 8'h00
`define FFQ_RESET_THRESHOLD 9'h008
`define FFQ_DEPTH_SMALL 10'h0FF
`define FFQ_DEPTH_LARGE 10'h200
`define FFQ_CMD_IDLE 5'h00
`define FFQ_CMD_LAST_KNOWN 5'h0F
`endif

// file: design/ffq_pkg.sv
/*
  types shared by the buffer bookkeeping block.
  assumes the constants header is included where numbers are needed.
*/
`default_nettype none
package ffq_pkg;
  typedef enum logic {FFQ_CMD_IDLE_ST, FFQ_CMD_RUN_ST} ffq_cmd_state_t;
endpackage
`default_nettype wire

// file: design/ffq_fifo_status.sv
/*
  byte buffer with fill count, threshold alarms and the first event
  status register, reached over a plain register port.
  assumes strobes are one cycle, never together, synchronous to
  ref_clk_i; link-side events arrive as one-cycle pulses.
*/
// Decided for this implementation: the plain strobed port.
//
// Behaviour
// - 8-bit threshold; 512-byte mode adds a ninth bit in control.
// - near-empty reads 1 when fill count is at or below threshold.
// - near-full reads 1 when depth minus fill is at or below threshold.
// - read-only 8-bit fill count, reset 00h; two upper bits in control.
// - data port write pushes and increments; read pops and decrements.
// - address pointer stays on data port access, else auto-increments.
// - 8-bit data port is the only byte path in and out.
// - depth-select 1 gives 255 bytes, 0 gives 512 bytes.
// - writing buffer-clear empties the buffer; the bit reads 0.
// - status write bit 7 selects set or clear of bits written 1.
// - near-full event latches on the flag rising, held until cleared.
// - near-empty event latches on the flag rising, held until cleared.
// - command-done sets when a running command ends by itself.
// - unknown command returns to idle and sets command-done.
// - host writing idle command does not set command-done.
// - transmit-done sets right after the last bit is sent.
// - receive-done sets at end of stream, correct data or not.
// - error event sets when any listed error flag becomes set.
// - start-of-frame event sets on frame start or subcarrier.
`include "ffq_params.svh"
`default_nettype none
module ffq_fifo_status #(
  parameter int MEM_DEPTH = 512,
  parameter int ADDR_W = 9
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // events from the link side, one-cycle pulses
  input wire logic cmd_finished_i,
  input wire logic tx_last_bit_i,
  input wire logic rx_end_i,
  input wire logic rx_sof_i,
  input wire logic fifo_write_error_i,
  input wire logic protocol_error_i,
  input wire logic missing_data_error_i,
  input wire logic integrity_error_i,
  // status outputs
  output logic [4:0] cmd_code_o,
  output logic [7:0] reg_ptr_o,
  output logic near_full_flag_o,
  output logic near_empty_flag_o
);
  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [ADDR_W-1:0] wr_ptr;
  logic [ADDR_W-1:0] rd_ptr;
  logic [9:0] fill;
  logic depth_select;
  logic [8:0] threshold;
  logic [6:0] irq_status;
  logic overflow_err;
  logic [4:0] cmd_code;
  ffq_pkg::ffq_cmd_state_t cmd_state;
  logic near_full_d;
  logic near_empty_d;
  logic [9:0] depth;
  logic [8:0] thr_eff;
  logic full;
  logic empty;
  logic wr_data;
  logic rd_data;
  logic do_push;
  logic do_pop;
  logic do_clear;
  logic near_full;
  logic near_empty;
  logic wr_ctrl;
  logic wr_cmd;
  logic cmd_known;
  logic [6:0] hw_set;
  logic [7:0] next_rdata;
  logic [9:0] fill_ro;

  // depth and threshold as seen in the current mode
  // the ninth threshold bit is ignored in the small mode, so a stale
  // value left over from the large mode cannot move the alarms
  always_comb
  begin
    depth = depth_select ? `FFQ_DEPTH_SMALL : `FFQ_DEPTH_LARGE;
    thr_eff = depth_select ? {1'b0, threshold[7:0]} : threshold;
  end

  // decode of register strobes
  // a clear beats a push or pop that arrives in the same cycle
  assign wr_data = reg_wr_i && (reg_addr_i == `FFQ_ADDR_DATA_PORT);
  assign rd_data = reg_rd_i && (reg_addr_i == `FFQ_ADDR_DATA_PORT);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `FFQ_ADDR_BUF_CTRL);
  assign wr_cmd = reg_wr_i && (reg_addr_i == `FFQ_ADDR_CMD);
  assign full = (fill >= depth);
  assign empty = (fill == 10'h000);
  assign do_clear = wr_ctrl && reg_wdata_i[`FFQ_CTRL_CLEAR];
  assign do_push = wr_data && !full && !do_clear;
  assign do_pop = rd_data && !empty && !do_clear;

  // threshold alarms
  // plain compares; the depth subtraction cannot wrap while the fill
  // stays within the depth of the current mode
  assign near_empty = ({1'b0, thr_eff} >= fill);
  assign near_full = ((depth - fill) <= {1'b0, thr_eff});

  // buffer storage, written only through the data port
  always_ff @(posedge ref_clk_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= reg_wdata_i;
    end
  end

  // pointers and fill count
  // pointers wrap at the array end in both modes; in the small mode the
  // fill count alone keeps the buffer to its shorter depth
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= 10'h000;
    end
    else if (do_clear)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= 10'h000;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (32'(wr_ptr) == MEM_DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (32'(rd_ptr) == MEM_DEPTH - 1) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        fill <= fill + 10'h001;
      end
      else if (do_pop && !do_push)
      begin
        fill <= fill - 10'h001;
      end
    end
  end

  // overflow error flag, sticky until written with one to clear
  // a new overflow beats a clear written in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      overflow_err <= 1'b0;
    end
    else if (wr_data && full)
    begin
      overflow_err <= 1'b1;
    end
    else if (reg_wr_i && reg_addr_i == `FFQ_ADDR_ERR_FLAGS &&
             reg_wdata_i[`FFQ_ERR_OVERFLOW])
    begin
      overflow_err <= 1'b0;
    end
  end

  // control register fields
  // a control write always rewrites depth select and the ninth threshold
  // bit; software should change the depth only while the buffer is empty
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      depth_select <= 1'b0;
      threshold <= `FFQ_RESET_THRESHOLD;
    end
    else
    begin
      if (wr_ctrl)
      begin
        depth_select <= reg_wdata_i[`FFQ_CTRL_DEPTH_SEL];
        threshold[8] <= reg_wdata_i[`FFQ_CTRL_THR_EXT];
      end
      if (reg_wr_i && reg_addr_i == `FFQ_ADDR_THRESHOLD)
      begin
        threshold[7:0] <= reg_wdata_i;
      end
    end
  end

  // command field: runs until the link side reports it finished
  // an unknown code is refused at once and reported as a finished command
  assign cmd_known = (reg_wdata_i[4:0] <= `FFQ_CMD_LAST_KNOWN);
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_code <= `FFQ_CMD_IDLE;
      cmd_state <= ffq_pkg::FFQ_CMD_IDLE_ST;
    end
    else if (wr_cmd)
    begin
      if (reg_wdata_i[4:0] == `FFQ_CMD_IDLE || !cmd_known)
      begin
        cmd_code <= `FFQ_CMD_IDLE;
        cmd_state <= ffq_pkg::FFQ_CMD_IDLE_ST;
      end
      else
      begin
        cmd_code <= reg_wdata_i[4:0];
        cmd_state <= ffq_pkg::FFQ_CMD_RUN_ST;
      end
    end
    else
    begin
      unique case (cmd_state)
        ffq_pkg::FFQ_CMD_IDLE_ST:
        begin
          cmd_state <= ffq_pkg::FFQ_CMD_IDLE_ST;
        end
        ffq_pkg::FFQ_CMD_RUN_ST:
        begin
          if (cmd_finished_i)
          begin
            cmd_code <= `FFQ_CMD_IDLE;
            cmd_state <= ffq_pkg::FFQ_CMD_IDLE_ST;
          end
        end
      endcase
    end
  end

  // rising-edge memory of the alarms
  // both reset low, so the empty buffer after reset reports one
  // near-empty event at the first edge
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      near_full_d <= 1'b0;
      near_empty_d <= 1'b0;
    end
    else
    begin
      near_full_d <= near_full;
      near_empty_d <= near_empty;
    end
  end

  // hardware event sources of the status register
  always_comb
  begin
    hw_set = 7'h00;
    hw_set[`FFQ_IRQ_NEAR_FULL] = near_full && !near_full_d;
    hw_set[`FFQ_IRQ_NEAR_EMPTY] = near_empty && !near_empty_d;
    hw_set[`FFQ_IRQ_CMD_DONE] =
      (!wr_cmd && cmd_state == ffq_pkg::FFQ_CMD_RUN_ST && cmd_finished_i) ||
      (wr_cmd && !cmd_known);
    hw_set[`FFQ_IRQ_TX_DONE] = tx_last_bit_i;
    hw_set[`FFQ_IRQ_RX_DONE] = rx_end_i;
    hw_set[`FFQ_IRQ_ERROR] = fifo_write_error_i || (wr_data && full) ||
      protocol_error_i || missing_data_error_i ||
      integrity_error_i;
    hw_set[`FFQ_IRQ_SOF] = rx_sof_i;
  end

  // event status register with set/clear write mode
  // hardware events are ored in after the host mask so none is lost
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_status <= 7'h00;
    end
    else if (reg_wr_i && reg_addr_i == `FFQ_ADDR_IRQ_FIRST)
    begin
      if (reg_wdata_i[`FFQ_IRQ_SET])
      begin
        irq_status <= irq_status | reg_wdata_i[6:0] | hw_set;
      end
      else
      begin
        irq_status <= (irq_status & ~reg_wdata_i[6:0]) | hw_set;
      end
    end
    else
    begin
      irq_status <= irq_status | hw_set;
    end
  end

  // internal register pointer, held on data port access
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_ptr_o <= `FFQ_RESET_BYTE;
    end
    else if ((reg_wr_i || reg_rd_i) &&
             reg_addr_i != `FFQ_ADDR_DATA_PORT)
    begin
      // data port accesses leave the pointer where it stands
      reg_ptr_o <= reg_addr_i + 8'h01;
    end
  end

  // read data mux
  assign fill_ro = depth_select ? {2'b00, fill[7:0]} : fill;
  always_comb
  begin
    next_rdata = `FFQ_RESET_BYTE;
    unique case (reg_addr_i)
      `FFQ_ADDR_CMD: next_rdata = {3'b000, cmd_code};
      `FFQ_ADDR_BUF_CTRL: next_rdata = {depth_select, near_full, near_empty,
        1'b0, 1'b0, threshold[8], fill_ro[9:8]};
      `FFQ_ADDR_THRESHOLD: next_rdata = threshold[7:0];
      `FFQ_ADDR_FILL_COUNT: next_rdata = fill_ro[7:0];
      `FFQ_ADDR_DATA_PORT: next_rdata = empty ? `FFQ_RESET_BYTE : mem[rd_ptr];
      `FFQ_ADDR_IRQ_FIRST: next_rdata = {1'b0, irq_status};
      `FFQ_ADDR_ERR_FLAGS: next_rdata = {6'h00, overflow_err, 1'b0};
      `FFQ_ADDR_PTR: next_rdata = reg_ptr_o;
      default: next_rdata = `FFQ_RESET_BYTE;
    endcase
  end

  // registered read data, valid the cycle after the read strobe
  // zero outside the data cycle so stale bytes never reach the host
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= `FFQ_RESET_BYTE;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= next_rdata;
    end
    else
    begin
      reg_rdata_o <= `FFQ_RESET_BYTE;
    end
  end

  // registered status outputs
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_code_o <= `FFQ_CMD_IDLE;
      near_full_flag_o <= 1'b0;
      near_empty_flag_o <= 1'b0;
    end
    else
    begin
      cmd_code_o <= cmd_code;
      near_full_flag_o <= near_full;
      near_empty_flag_o <= near_empty;
    end
  end
endmodule
`default_nettype wire

// file: verification/ffq_host.sv
/*
  host register master model for the buffer block.
  assumes one clock; the bench calls its tasks right after an edge.
*/
`default_nettype none
module ffq_host (
  // clock
  input wire logic clk_i,
  // register port
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  // write strobe held to its sampling edge, then bus scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // read strobe, data taken once the sampling edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: verification/ffq_fifo_status_sva.sv
/*
  port checks of the buffer block.
  assumes one clock domain; attached by the bind below.
*/
`default_nettype none
module ffq_fifo_status_sva (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // events
  input wire logic tx_last_bit_i,
  input wire logic rx_end_i,
  input wire logic rx_sof_i,
  // status
  input wire logic [4:0] cmd_code_o,
  input wire logic [7:0] reg_ptr_o
);
  // access decodes
  wire logic acc = reg_wr_i | reg_rd_i;
  wire logic rd6 = reg_rd_i && reg_addr_i == 8'h06;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_ptr_step: assert property (acc && reg_addr_i != 8'h05 |=>
    reg_ptr_o - $past(reg_addr_i) == 8'h01) else $error("pointer no step");
  a_ptr_keep: assert property (acc && reg_addr_i == 8'h05 |=>
    $stable(reg_ptr_o)) else $error("pointer moved");
  a_set_msb: assert property (rd6 |=> !reg_rdata_o[7])
    else $error("status bit 7 read");
  a_clear_rd0: assert property (reg_rd_i && reg_addr_i == 8'h02 |=>
    !reg_rdata_o[4]) else $error("clear bit read 1");
  a_unknown_cmd: assert property (reg_wr_i && reg_addr_i == 8'h00 &&
    reg_wdata_i[4:0] > 5'h0F |-> ##[1:3] cmd_code_o == 5'h00)
    else $error("unknown command kept");
  a_sof_event: assert property (rx_sof_i ##1 rd6 |=> reg_rdata_o[0])
    else $error("frame start lost");
  a_tx_event: assert property (tx_last_bit_i ##1 rd6 |=>
    reg_rdata_o[3]) else $error("transmit done lost");
  a_rx_event: assert property (rx_end_i ##1 rd6 |=> reg_rdata_o[2])
    else $error("receive done lost");
  c_error_seen: cover property (rd6 ##1 reg_rdata_o[1]);
  c_port_access: cover property (acc && reg_addr_i == 8'h05);
  c_set_clash: cover property (rx_sof_i && reg_wr_i);
endmodule
bind ffq_fifo_status ffq_fifo_status_sva sva_u (.ref_clk_i, .rst_b_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .tx_last_bit_i, .rx_end_i, .rx_sof_i, .cmd_code_o, .reg_ptr_o);
`default_nettype wire

// file: verification/ffq_fifo_status_tb.sv
/*
  self-checking bench of the buffer block.
  assumes the host model drives the register port.
*/
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module ffq_fifo_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr, wdata, rdata, d, ptr;
  logic [7:0] ev = 8'h00;
  logic wr, rd, nf, ne;
  logic [4:0] cmd;
  int error_cnt = 0;
  int check_count = 0;
  // clock and one-cycle event pulses
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (ev != 8'h00) ev <= 8'h00;
  ffq_host h (.clk_i(ref_clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  ffq_fifo_status dut_u (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .cmd_finished_i(ev[4]), .tx_last_bit_i(ev[3]),
    .rx_end_i(ev[2]), .rx_sof_i(ev[0]), .fifo_write_error_i(ev[1]),
    .protocol_error_i(ev[5]), .missing_data_error_i(ev[6]),
    .integrity_error_i(ev[7]), .cmd_code_o(cmd), .reg_ptr_o(ptr),
    .near_full_flag_o(nf), .near_empty_flag_o(ne));
  // shared read and push
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    h.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++) h.wr(8'h05, 8'(i));
  endtask
  task automatic t_reset;
    rchk(8'h04, 8'h00);
    rchk(8'h02, 8'h20);
    rchk(8'h03, 8'h08);
    rchk(8'h06, 8'h20);
    h.wr(8'h04, 8'h55);
    rchk(8'h04, 8'h00);
    rchk(8'h30, 8'h00);
  endtask
  task automatic t_push_pop;
    h.wr(8'h05, 8'hA1);
    h.wr(8'h05, 8'hB2);
    rchk(8'h04, 8'h02);
    rchk(8'h05, 8'hA1);
    `CHK(ptr, 8'h05)
    rchk(8'h04, 8'h01);
    h.wr(8'h02, 8'h10);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
  endtask
  task automatic t_levels;
    h.wr(8'h06, 8'h7F);
    push(9);
    rchk(8'h06, 8'h00);
    `CHK(ne, 1'b0)
    h.rd(8'h05, d);
    rchk(8'h04, 8'h08);
    `CHK(ne, 1'b1)
    rchk(8'h06, 8'h20);
    push(248);
    rchk(8'h04, 8'h00);
    rchk(8'h02, 8'h01);
    h.wr(8'h02, 8'h04);
    rchk(8'h02, 8'h65);
    h.wr(8'h02, 8'h00);
    rchk(8'h06, 8'h60);
    `CHK(nf, 1'b0)
    h.wr(8'h02, 8'h10);
  endtask
  task automatic t_overflow;
    h.wr(8'h02, 8'h80);
    h.wr(8'h06, 8'h7F);
    push(246);
    rchk(8'h04, 8'hF6);
    `CHK(nf, 1'b0)
    push(1);
    rchk(8'h04, 8'hF7);
    `CHK(nf, 1'b1)
    push(9);
    rchk(8'h04, 8'hFF);
    h.rd(8'h0A, d);
    `CHK(d[1], 1'b1)
    rchk(8'h06, 8'h42);
    h.wr(8'h0A, 8'h02);
    h.wr(8'h02, 8'h10);
  endtask
  task automatic t_irq_write;
    rchk(8'h04, 8'h00);
    h.wr(8'h06, 8'h7F);
    rchk(8'h06, 8'h00);
    h.wr(8'h06, 8'hFF);
    rchk(8'h06, 8'h7F);
    h.wr(8'h06, 8'h7F);
    h.wr(8'h06, 8'h85);
    rchk(8'h06, 8'h05);
    h.wr(8'h06, 8'h04);
    rchk(8'h06, 8'h01);
  endtask
  task automatic t_events;
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4) continue;
      h.wr(8'h06, 8'h7F);
      @(posedge ref_clk);
      ev <= 8'(1 << i);
      rchk(8'h06, 8'h01 << (i > 4 ? 1 : i));
      h.rd(8'h0A, d);
      `CHK(d[1], 1'b0)
    end
    h.wr(8'h06, 8'h7F);
    fork
      h.wr(8'h06, 8'h01);
      begin
        @(posedge ref_clk);
        ev <= 8'h01;
      end
    join
    rchk(8'h06, 8'h01);
  endtask
  task automatic t_cmd;
    h.wr(8'h06, 8'h7F);
    h.wr(8'h00, 8'h03);
    repeat (2) @(posedge ref_clk);
    `CHK(cmd, 5'h03)
    ev <= 8'h10;
    rchk(8'h06, 8'h10);
    `CHK(cmd, 5'h00)
    h.wr(8'h06, 8'h7F);
    h.wr(8'h00, 8'h03);
    h.wr(8'h00, 8'h00);
    rchk(8'h06, 8'h00);
    `CHK(cmd, 5'h00)
    h.wr(8'h00, 8'h03);
    h.wr(8'h00, 8'h1F);
    rchk(8'h06, 8'h10);
    `CHK(cmd, 5'h00)
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence and hang guard
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_push_pop;
    t_levels;
    t_overflow;
    t_irq_write;
    t_events;
    t_cmd;
    end_of_test;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
